//--- serial_peer.sv
// far-side serial slave that sends a fixed pattern to the master
`timescale 1ns/1ns
module serial_peer #(
  parameter logic [7:0] PATTERN = 8'h3c
)
(
  input wire logic sck_in,
  input wire logic sel_n_in,
  output logic miso_out
);
  logic [7:0] sh_q;
  // load on select, shift on falling clock, msb first
  initial
  begin
    sh_q = PATTERN;
    miso_out = 1'b0;
  end
  always @(negedge sel_n_in)
  begin
    sh_q = PATTERN;
    miso_out = PATTERN[7];
  end
  always @(negedge sck_in)
  begin
    sh_q = {sh_q[6:0], 1'b0};
    miso_out = sel_n_in ? miso_out : sh_q[7];
  end
  // released line: last value inverted
  always @(posedge sel_n_in) miso_out = ~miso_out;
endmodule

//--- spi_sel_cfg.svh
// register offsets, field positions, reset values and frame figures of the select controller
`ifndef SPI_SEL_CFG_SVH
`define SPI_SEL_CFG_SVH
`define OFF_CTRL_ONE 8'h00
`define OFF_DATA 8'h04
`define OFF_STATUS 8'h08
`define OFF_ACCESS 8'h0c
`define OFF_CTRL_TWO 8'h10
`define OFF_DCTRL_TWO 8'h14
`define OFF_BITRATE 8'h18
`define OFF_CMD_BASE 8'h20
`define C1_EN 0
`define C1_MST 1
`define C1_MM 2
`define C1_LOOP 3
`define C1_MOSI_IDLE 4
`define C1_STOP 5
`define C1_INIT 6
`define C1_POL 8
`define SR_OVR 0
`define SR_IDLE 1
`define SR_MODE_FAULT_FLAG 2
`define SR_PER 3
`define SR_UDR 4
`define SR_TXE 5
`define SR_RXF 6
`define AC_BYTE 0
`define AC_LW 1
`define C2_PE 0
`define C2_ODD 1
`define C2_ASE 2
`define RST_C1 12'h000
`define RST_AC 2'h0
`define RST_C2 3'h0
`define RST_BR 8'h00
`define FLEN_MIN 6'h08
`define FLEN_20 6'h14
`define FLEN_24 6'h18
`define FLEN_MAX 6'h20
`endif

//--- spi_sel_pkg.sv
// types shared by the serial select controller
package spi_sel_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_LEAD = 6'h02,
    ST_SHIFT = 6'h04,
    ST_HOLD = 6'h08,
    ST_TAIL = 6'h10,
    ST_NEXT = 6'h20
  } eng_state_e;
  // one command slot, 21 bits, high bits first
  typedef struct packed {
    logic [2:0] next_dly;
    logic [2:0] neg_dly;
    logic [2:0] clk_dly;
    logic burst;
    logic lsb_first;
    logic [3:0] len;
    logic cpha;
    logic cpol;
    logic [1:0] brdv;
    logic [1:0] sel;
  } cmd_s;
  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
    logic [3:0] sel;
    logic [3:0] sel_oe;
  } pins_s;
endpackage

//--- spi_select_ctrl.sv
// serial peripheral interface with select control, command sequencer and apb registers
// Summary of operation
// - four select lines; single-master drives all four as outputs
// - multi-master: line 0 is input, lines 1 to 3 outputs
// - slave: line 0 is the select input, lines 1 to 3 unused
// - master waits 1 to 8 clock cycles from select to first clock
// - master waits 1 to 8 clock cycles from clock stop to negation
// - master waits 1 to 8 clock cycles before the next select
// - active level of each select line is programmable
// - up to eight commands run in turn, wrapping to the first
// - each command holds select, rate, mode, length, order, burst, delays
// - writing the transmit buffer starts a master transfer
// - data output level while select is negated is programmable
// - enable bit turns on clock auto-stop; cleared means off
// - receive full, transmit empty and idle requests
// - one error request for mode fault, overrun, underrun, parity
// - mode fault flag reads fault or underrun; separate underrun flag
// - data window width: longword, word or byte by access bits
// - parity enable appends parity and checks received frames
// - software initialisation of the interface and internal loopback
// - module stop halts the interface
// - frame length 8 to 16, 20, 24 or 32 bits; msb or lsb first
// - master clock divides system clock by 2 up to 4096
`timescale 1ns/1ns
`include "spi_sel_cfg.svh"
module spi_select_ctrl
  import spi_sel_pkg::*;
#(
  parameter int CMD_SLOTS = 8
)
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic serial_shift_clock_in,
  output logic serial_shift_clock_out,
  output logic serial_shift_clock_oe_out,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_out,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_out,
  input wire logic select_line_0_in,
  output logic [3:0] slave_select_line_out,
  output logic [3:0] slave_select_line_oe_out,
  output logic rx_full_req_out,
  output logic tx_empty_req_out,
  output logic error_req_out,
  output logic idle_req_out
);
  localparam int PW = $clog2(CMD_SLOTS);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // data bits of a frame from its length code
  function automatic logic [5:0] frame_bits(input logic [3:0] len);
    if (len <= 4'h8)
      frame_bits = `FLEN_MIN + {2'h0, len};
    else if (len == 4'h9)
      frame_bits = `FLEN_20;
    else if (len == 4'ha)
      frame_bits = `FLEN_24;
    else
      frame_bits = `FLEN_MAX;
  endfunction

  // word position of the idx-th bit on the wire
  function automatic logic [4:0] bit_pos(input logic [5:0] idx, input logic [5:0] fb,
                                         input logic lsb);
    logic [5:0] p;
    p = lsb ? idx : 6'(fb - 6'h01 - idx);
    bit_pos = p[4:0];
  endfunction

  // 32 bits shift to zero, so the minus one gives all ones
  function automatic logic [31:0] len_mask(input logic [5:0] fb);
    len_mask = (32'h1 << fb) - 32'h1;
  endfunction

  function automatic logic [31:0] acc_mask(input logic [1:0] ac);
    if (ac[`AC_BYTE])
      acc_mask = 32'h0000_00ff;
    else if (ac[`AC_LW])
      acc_mask = 32'hffff_ffff;
    else
      acc_mask = 32'h0000_ffff;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic [11:0] c1_q, c1_d;
  logic [1:0] ac_q, ac_d;
  logic [2:0] c2_q, c2_d;
  logic [PW-1:0] last_q, last_d, ptr_q, ptr_d;
  logic [7:0] br_q, br_d;
  cmd_s cmd_mem_q [CMD_SLOTS];
  cmd_s cmd_mem_d [CMD_SLOTS];
  cmd_s cmd_q, cmd_d;
  eng_state_e st_q, st_d;
  logic [11:0] div_q, div_d;
  logic [3:0] hcnt_q, hcnt_d;
  logic [6:0] ecnt_q, ecnt_d;
  logic [5:0] ocnt_q, ocnt_d, scnt_q, scnt_d;
  logic [31:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d, tx_buf_q, tx_buf_d, rx_buf_q, rx_buf_d;
  logic rpar_q, rpar_d, sck_q, sck_d, act_q, act_d;
  logic tx_full_q, tx_full_d, rx_full_q, rx_full_d;
  logic ovr_q, ovr_d, mode_fault_flag_q, mode_fault_flag_d, udr_q, udr_d, per_q, per_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  pins_s pins_q, pins_d;
  logic [3:0] req_q, req_d;
  logic sck_s1, sck_s2, sck_s3, mosi_s1, mosi_s2, miso_s1, miso_s2, ssl_s1, ssl_s2;
  logic apb_wr, apb_rd, run, mst_run, slv_run, ssl0_act, tick, edge_ev, lead, samp, adv;
  logic frame_done, do_store, finish, start, out_bit, tx_par, in_bit;
  logic [5:0] fb, nb, cidx;
  logic [11:0] half;
  logic [31:0] amask, store_data;
  logic [7:0] status;
  logic [15:0] dwell_q;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // two stages before any logic; the third sck stage only feeds edge detection
  always_ff @(posedge sys_clk_in)
  begin
    sck_s1 <= serial_shift_clock_in;
    sck_s2 <= sck_s1;
    sck_s3 <= sck_s2;
    mosi_s1 <= mosi_in;
    mosi_s2 <= mosi_s1;
    miso_s1 <= miso_in;
    miso_s2 <= miso_s1;
    ssl_s1 <= select_line_0_in;
    ssl_s2 <= ssl_s1;
  end

  // ****************************************************************
  // registers, bus slave and transfer engine
  // ****************************************************************
  always_comb
  begin
    c1_d = c1_q;
    ac_d = ac_q;
    c2_d = c2_q;
    last_d = last_q;
    br_d = br_q;
    cmd_mem_d = cmd_mem_q;
    cmd_d = cmd_q;
    ptr_d = ptr_q;
    st_d = st_q;
    ecnt_d = ecnt_q;
    ocnt_d = ocnt_q;
    scnt_d = scnt_q;
    tx_sh_d = tx_sh_q;
    rx_sh_d = rx_sh_q;
    tx_buf_d = tx_buf_q;
    rx_buf_d = rx_buf_q;
    rpar_d = rpar_q;
    sck_d = sck_q;
    act_d = act_q;
    tx_full_d = tx_full_q;
    rx_full_d = rx_full_q;
    ovr_d = ovr_q;
    mode_fault_flag_d = mode_fault_flag_q;
    udr_d = udr_q;
    per_d = per_q;
    amask = acc_mask(ac_q);
    apb_wr = psel_in && penable_in && pready_q && pwrite_in && !pslverr_q;
    apb_rd = psel_in && penable_in && pready_q && !pwrite_in && !pslverr_q;
    cidx = 6'((paddr_in - `OFF_CMD_BASE) >> 2);
    run = c1_q[`C1_EN] && !c1_q[`C1_STOP];
    mst_run = run && c1_q[`C1_MST];
    slv_run = run && !c1_q[`C1_MST];
    ssl0_act = (ssl_s2 == c1_q[`C1_POL]);
    fb = frame_bits(cmd_q.len);
    nb = fb + {5'h00, c2_q[`C2_PE]};
    half = 12'(({4'h0, br_q} + 12'h001) << cmd_q.brdv);
    tick = (div_q == half - 12'h001);
    tx_par = ^(tx_sh_q & len_mask(fb)) ^ c2_q[`C2_ODD];
    out_bit = (ocnt_q < fb) ? tx_sh_q[bit_pos(ocnt_q, fb, cmd_q.lsb_first)] : tx_par;
    in_bit = c1_q[`C1_LOOP] ? out_bit : (c1_q[`C1_MST] ? miso_s2 : mosi_s2);
    status = 8'h00;
    status[`SR_OVR] = ovr_q;
    status[`SR_IDLE] = (st_q == ST_IDLE) && !tx_full_q;
    status[`SR_MODE_FAULT_FLAG] = mode_fault_flag_q || udr_q;
    status[`SR_PER] = per_q;
    status[`SR_UDR] = udr_q;
    status[`SR_TXE] = !tx_full_q;
    status[`SR_RXF] = rx_full_q;
    // read data is fetched in the setup phase so the answer needs no wait state
    prdata_d = 32'h0;
    pslverr_d = 1'b0;
    pready_d = psel_in && !penable_in;
    if (psel_in && !penable_in)
    begin
      case (paddr_in)
        `OFF_CTRL_ONE: prdata_d = {20'h0, c1_q};
        `OFF_DATA: prdata_d = rx_buf_q & amask;
        `OFF_STATUS: prdata_d = {24'h0, status};
        `OFF_ACCESS: prdata_d = {30'h0, ac_q};
        `OFF_CTRL_TWO: prdata_d = {29'h0, c2_q};
        `OFF_DCTRL_TWO: prdata_d = 32'(last_q);
        `OFF_BITRATE: prdata_d = {24'h0, br_q};
        default:
        begin
          if (paddr_in >= `OFF_CMD_BASE && paddr_in[1:0] == 2'h0 && cidx < 6'(CMD_SLOTS))
            prdata_d = {11'h0, cmd_mem_q[cidx[PW-1:0]]};
          else
            pslverr_d = 1'b1;
        end
      endcase
    end
    // clears come before the engine so a same-cycle event wins
    if (apb_rd && paddr_in == `OFF_DATA)
      rx_full_d = 1'b0;
    if (apb_wr && paddr_in == `OFF_STATUS)
    begin
      if (pwdata_in[`SR_OVR])
        ovr_d = 1'b0;
      if (pwdata_in[`SR_MODE_FAULT_FLAG])
      begin
        mode_fault_flag_d = 1'b0;
        udr_d = 1'b0;
      end
      if (pwdata_in[`SR_PER])
        per_d = 1'b0;
      if (pwdata_in[`SR_UDR])
        udr_d = 1'b0;
    end
    // clock edges: own divider as master, synchronised pin as slave
    if (c1_q[`C1_MST])
    begin
      edge_ev = (st_q == ST_SHIFT) && tick && mst_run;
      lead = !ecnt_q[0];
    end
    else
    begin
      edge_ev = (st_q == ST_SHIFT) && slv_run && (sck_s2 != sck_s3);
      lead = (sck_s3 == cmd_q.cpol);
    end
    samp = edge_ev && (cmd_q.cpha ? !lead : lead);
    adv = edge_ev && (cmd_q.cpha ? (lead && ecnt_q != 7'h00) : !lead);
    if (edge_ev)
    begin
      ecnt_d = ecnt_q + 7'h01;
      if (c1_q[`C1_MST])
        sck_d = !sck_q;
    end
    if (adv)
      ocnt_d = ocnt_q + 6'h01;
    if (samp)
    begin
      scnt_d = scnt_q + 6'h01;
      if (scnt_q < fb)
        rx_sh_d[bit_pos(scnt_q, fb, cmd_q.lsb_first)] = in_bit;
      else
        rpar_d = in_bit;
    end
    frame_done = edge_ev && (ecnt_q + 7'h01 == {nb, 1'b0});
    // auto-stop parks the clock instead of overrunning a full receive buffer
    do_store = (frame_done && !(c1_q[`C1_MST] && c2_q[`C2_ASE] && rx_full_d))
               || (st_q == ST_HOLD && !rx_full_d);
    store_data = (st_q == ST_HOLD) ? rx_sh_q : rx_sh_d;
    if (do_store)
    begin
      if (c2_q[`C2_PE] && ((^(store_data & len_mask(fb)) ^ c2_q[`C2_ODD]) != rpar_d))
        per_d = 1'b1;
      if (rx_full_d)
        ovr_d = 1'b1;
      else
      begin
        rx_buf_d = store_data;
        rx_full_d = 1'b1;
      end
    end
    finish = do_store && c1_q[`C1_MST];
    if (finish)
      ptr_d = (ptr_q == last_q) ? '0 : PW'(ptr_q + 1'b1);
    start = (st_q == ST_IDLE && mst_run && tx_full_q && !mode_fault_flag_q)
            || (finish && cmd_q.burst && tx_full_q);
    case (st_q)
      ST_IDLE:
      begin
        sck_d = cmd_q.cpol;
        if (slv_run && ssl0_act)
        begin
          st_d = ST_SHIFT;
          cmd_d = cmd_mem_q[0];
        end
      end
      // one half period less here: the shift state waits the last half before its first edge
      ST_LEAD:
        if (tick && hcnt_q == {cmd_q.clk_dly, 1'b0})
          st_d = ST_SHIFT;
      ST_SHIFT:
      begin
        if (c1_q[`C1_MST] && frame_done && c2_q[`C2_ASE] && rx_full_d)
          st_d = ST_HOLD;
        if (slv_run && !ssl0_act)
        begin
          st_d = ST_IDLE;
          if (ecnt_q != 7'h00)
            mode_fault_flag_d = 1'b1;
        end
      end
      ST_HOLD: sck_d = cmd_q.cpol;
      ST_TAIL:
        if (tick && hcnt_q == {cmd_q.neg_dly, 1'b1})
        begin
          st_d = ST_NEXT;
          act_d = 1'b0;
        end
      ST_NEXT:
        if (tick && hcnt_q == {cmd_q.next_dly, 1'b1})
          st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
    // slave frame boundary: fresh counters and the next transmit word
    if ((slv_run && st_q == ST_IDLE && ssl0_act) || (!c1_q[`C1_MST] && frame_done))
    begin
      ecnt_d = 7'h00;
      ocnt_d = 6'h00;
      scnt_d = 6'h00;
      rx_sh_d = 32'h0;
      if (tx_full_q)
      begin
        tx_sh_d = tx_buf_q;
        tx_full_d = 1'b0;
      end
      else
        udr_d = 1'b1;
    end
    if (finish)
      st_d = ST_TAIL;
    if (start)
    begin
      cmd_d = cmd_mem_q[ptr_d];
      tx_sh_d = tx_buf_q;
      tx_full_d = 1'b0;
      act_d = 1'b1;
      st_d = ST_LEAD;
      ecnt_d = 7'h00;
      ocnt_d = 6'h00;
      scnt_d = 6'h00;
      rx_sh_d = 32'h0;
      sck_d = cmd_mem_q[ptr_d].cpol;
    end
    // a foreign master driving line 0 takes the bus away
    if (mst_run && c1_q[`C1_MM] && ssl0_act)
    begin
      mode_fault_flag_d = 1'b1;
      st_d = ST_IDLE;
      act_d = 1'b0;
    end
    if (!run)
    begin
      st_d = ST_IDLE;
      act_d = 1'b0;
      sck_d = cmd_q.cpol;
    end
    div_d = (st_d != st_q || tick) ? 12'h000 : div_q + 12'h001;
    hcnt_d = (st_d != st_q) ? 4'h0 : (tick ? hcnt_q + 4'h1 : hcnt_q);
    // configuration writes; a data write lands after the engine took the old word
    if (apb_wr)
    begin
      case (paddr_in)
        `OFF_CTRL_ONE:
        begin
          c1_d = pwdata_in[11:0];
          c1_d[`C1_INIT] = 1'b0;
        end
        `OFF_DATA:
        begin
          tx_buf_d = pwdata_in & amask;
          tx_full_d = 1'b1;
        end
        `OFF_ACCESS: ac_d = pwdata_in[1:0];
        `OFF_CTRL_TWO: c2_d = pwdata_in[2:0];
        `OFF_DCTRL_TWO: last_d = pwdata_in[PW-1:0];
        `OFF_BITRATE: br_d = pwdata_in[7:0];
        default:
          if (paddr_in >= `OFF_CMD_BASE)
            cmd_mem_d[cidx[PW-1:0]] = pwdata_in[20:0];
      endcase
    end
    // initialisation keeps configuration, clears engine, buffers and flags
    if (apb_wr && paddr_in == `OFF_CTRL_ONE && pwdata_in[`C1_INIT])
    begin
      st_d = ST_IDLE;
      act_d = 1'b0;
      ptr_d = '0;
      tx_full_d = 1'b0;
      rx_full_d = 1'b0;
      ovr_d = 1'b0;
      mode_fault_flag_d = 1'b0;
      udr_d = 1'b0;
      per_d = 1'b0;
    end
    // pins; select level follows the programmed polarity of each line
    pins_d.sck = sck_q;
    pins_d.sck_oe = mst_run;
    pins_d.mosi = act_q ? out_bit : c1_q[`C1_MOSI_IDLE];
    pins_d.mosi_oe = mst_run;
    pins_d.miso = out_bit;
    pins_d.miso_oe = slv_run && ssl0_act;
    for (int i = 0; i < 4; i++)
    begin
      pins_d.sel[i] = (act_q && mst_run && cmd_q.sel == 2'(i)) ? c1_q[`C1_POL + i]
                      : !c1_q[`C1_POL + i];
      pins_d.sel_oe[i] = mst_run && !(c1_q[`C1_MM] && i == 0);
    end
    req_d[0] = rx_full_q;
    req_d[1] = !tx_full_q && c1_q[`C1_EN];
    req_d[2] = ovr_q || mode_fault_flag_q || udr_q || per_q;
    req_d[3] = (st_q == ST_IDLE) && !tx_full_q && c1_q[`C1_EN];
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      c1_q <= `RST_C1;
      ac_q <= `RST_AC;
      c2_q <= `RST_C2;
      last_q <= '0;
      br_q <= `RST_BR;
      cmd_mem_q <= '{default: '0};
      cmd_q <= '0;
      ptr_q <= '0;
      st_q <= ST_IDLE;
      div_q <= 12'h000;
      hcnt_q <= 4'h0;
      ecnt_q <= 7'h00;
      ocnt_q <= 6'h00;
      scnt_q <= 6'h00;
      tx_sh_q <= 32'h0;
      rx_sh_q <= 32'h0;
      tx_buf_q <= 32'h0;
      rx_buf_q <= 32'h0;
      rpar_q <= 1'b0;
      sck_q <= 1'b0;
      act_q <= 1'b0;
      tx_full_q <= 1'b0;
      rx_full_q <= 1'b0;
      ovr_q <= 1'b0;
      mode_fault_flag_q <= 1'b0;
      udr_q <= 1'b0;
      per_q <= 1'b0;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      pins_q <= '0;
      req_q <= 4'h0;
    end
    else
    begin
      c1_q <= c1_d;
      ac_q <= ac_d;
      c2_q <= c2_d;
      last_q <= last_d;
      br_q <= br_d;
      cmd_mem_q <= cmd_mem_d;
      cmd_q <= cmd_d;
      ptr_q <= ptr_d;
      st_q <= st_d;
      div_q <= div_d;
      hcnt_q <= hcnt_d;
      ecnt_q <= ecnt_d;
      ocnt_q <= ocnt_d;
      scnt_q <= scnt_d;
      tx_sh_q <= tx_sh_d;
      rx_sh_q <= rx_sh_d;
      tx_buf_q <= tx_buf_d;
      rx_buf_q <= rx_buf_d;
      rpar_q <= rpar_d;
      sck_q <= sck_d;
      act_q <= act_d;
      tx_full_q <= tx_full_d;
      rx_full_q <= rx_full_d;
      ovr_q <= ovr_d;
      mode_fault_flag_q <= mode_fault_flag_d;
      udr_q <= udr_d;
      per_q <= per_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      pins_q <= pins_d;
      req_q <= req_d;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign serial_shift_clock_out = pins_q.sck;
  assign serial_shift_clock_oe_out = pins_q.sck_oe;
  assign mosi_out = pins_q.mosi;
  assign mosi_oe_out = pins_q.mosi_oe;
  assign miso_out = pins_q.miso;
  assign miso_oe_out = pins_q.miso_oe;
  assign slave_select_line_out = pins_q.sel;
  assign slave_select_line_oe_out = pins_q.sel_oe;
  assign rx_full_req_out = req_q[0];
  assign tx_empty_req_out = req_q[1];
  assign error_req_out = req_q[2];
  assign idle_req_out = req_q[3];

  // ****************************************************************
  // checks
  // ****************************************************************
  // cycles spent in the current engine state, read only by the delay checks
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in || st_d != st_q)
      dwell_q <= 16'h0000;
    else
      dwell_q <= dwell_q + 16'h0001;
  end

  AST_SINGLE_OE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (mst_run && !c1_q[`C1_MM]) |=> (slave_select_line_oe_out == 4'hf))
    else $error("single master does not drive all select lines");
  AST_MULTI_IN: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (mst_run && c1_q[`C1_MM]) |=> (!slave_select_line_oe_out[0] && slave_select_line_oe_out[3]))
    else $error("multi master select line roles wrong");
  AST_SLAVE_OFF: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    slv_run |=> (slave_select_line_oe_out == 4'h0 && !serial_shift_clock_oe_out))
    else $error("slave drives select or clock");
  AST_LEAD_LEN: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (st_q == ST_LEAD && st_d == ST_SHIFT)
    |-> (32'(dwell_q) + 1 == (2 * 32'(cmd_q.clk_dly) + 1) * 32'(half)))
    else $error("select to clock delay wrong");
  AST_TAIL_LEN: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (st_q == ST_TAIL && st_d == ST_NEXT)
    |-> (32'(dwell_q) + 1 == (32'(cmd_q.neg_dly) + 1) * 2 * 32'(half)))
    else $error("negation delay wrong");
  AST_NEXT_LEN: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (st_q == ST_NEXT && st_d == ST_IDLE && run && !(c1_q[`C1_MM] && ssl0_act) && !apb_wr)
    |-> (32'(dwell_q) + 1 == (32'(cmd_q.next_dly) + 1) * 2 * 32'(half)))
    else $error("next access delay wrong");
  AST_SEL_NEG: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (mst_run && !act_q) |=> (slave_select_line_out == ~$past(c1_q[`C1_POL +: 4])))
    else $error("select not negated while idle");
  AST_PTR_WRAP: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (finish && ptr_q == last_q && !apb_wr) |=> (ptr_q == '0))
    else $error("command pointer does not wrap");
  AST_START: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (st_q == ST_IDLE && mst_run && tx_full_q && !mode_fault_flag_q && !ssl0_act && !apb_wr)
    |=> (st_q == ST_LEAD && !tx_full_q ##1 serial_shift_clock_out == cmd_q.cpol))
    else $error("buffer write did not start a transfer");
  AST_MODE_FAULT_FLAG_READ: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (psel_in && !penable_in && paddr_in == `OFF_STATUS)
    |=> (prdata_out[`SR_MODE_FAULT_FLAG] == $past(mode_fault_flag_q || udr_q)))
    else $error("mode fault flag misreads");
  AST_BYTE_READ: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (psel_in && !penable_in && paddr_in == `OFF_DATA && ac_q[`AC_BYTE])
    |=> (prdata_out[31:8] == 24'h0))
    else $error("byte access returns upper bits");
  AST_ERR_REQ: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (ovr_q || mode_fault_flag_q || udr_q || per_q) |=> error_req_out)
    else $error("error request missing");
endmodule

//--- spi_select_ctrl_bench.sv
// self-checking bench for the select controller
`timescale 1ns/1ns
module spi_select_ctrl_bench;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, sck_i = 0, ss0 = 1, er;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic pready, perr, sck, miso, rxf, txe, err, idl;
  logic sck_oe, mosi, mosi_oe, so, so_oe, si = 1'b0;
  logic [3:0] slave_select_line, ssl_oe;
  int n_mismatch = 0, checks_done = 0, t;
  spi_select_ctrl DUT (.sys_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(pready),
    .pslverr_out(perr), .serial_shift_clock_in(sck_i), .serial_shift_clock_out(sck),
    .serial_shift_clock_oe_out(sck_oe), .mosi_in(si), .mosi_out(mosi), .mosi_oe_out(mosi_oe),
    .miso_in(miso), .miso_out(so), .miso_oe_out(so_oe), .select_line_0_in(ss0),
    .slave_select_line_out(slave_select_line),
    .slave_select_line_oe_out(ssl_oe), .rx_full_req_out(rxf), .tx_empty_req_out(txe),
    .error_req_out(err), .idle_req_out(idl));
  serial_peer peer (.sck_in(sck), .sel_n_in(slave_select_line[0]), .miso_out(miso));
  // ********
  // bus tasks
  // ********
  always #50 clk = ~clk;
  // one apb transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    t = 0;
    do @(posedge clk); while (pready !== 1'b1 && ++t < 50);
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      $display("BAD %0t no pready", $time);
    end
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // idle level lags the write by a few cycles, so wait before polling
  task automatic wait_idle();
    repeat (4) @(posedge clk);
    t = 0;
    do @(posedge clk); while (idl !== 1'b1 && ++t < 2000);
    if (idl !== 1'b1)
    begin
      n_mismatch++;
      $display("BAD %0t never idle", $time);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #3000000;
    n_mismatch++;
    final_report();
  end
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, 8'h00, 0);
    chk(rd, 0);
    apb(0, 8'h02, 0);
    chk(er, 1);
    apb(1, 8'h00, 32'h3);
    chk({ssl_oe, slave_select_line}, 8'hff);
    apb(1, 8'h00, 32'h13);
    chk({sck_oe, mosi_oe, mosi}, 3'h7);
    apb(1, 8'h00, 32'h7);
    chk(ssl_oe, 4'he);
    apb(1, 8'h00, 32'h1);
    chk(ssl_oe, 4'h0);
    apb(1, 8'h00, 32'h23);
    chk({ssl_oe, sck_oe}, 5'h00);
    apb(1, 8'h00, 32'h103);
    chk(slave_select_line[0], 0);
    apb(1, 8'h00, 32'h3);
    apb(1, 8'h0c, 0);
    apb(1, 8'h18, 32'h3);
    apb(1, 8'h20, 32'h1000);
    apb(1, 8'h14, 0);
    apb(1, 8'h04, 32'ha5);
    t = 0;
    do @(posedge clk); while (slave_select_line[0] !== 1'b0 && ++t < 100);
    // cycles from select seen asserted to first clock edge seen
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (sck !== 1'b1 && t < 100);
    chk(t, 16);
    wait_idle();
    chk(rxf, 1);
    chk(txe, 1);
    apb(0, 8'h04, 0);
    chk(rd, 32'h3c);
    apb(0, 8'h08, 0);
    chk(rd[6], 0);
    apb(1, 8'h00, 32'hb);
    apb(1, 8'h04, 32'h5a);
    wait_idle();
    apb(0, 8'h04, 0);
    chk(rd, 32'h5a);
    // loopback again with parity on and lsb first
    apb(1, 8'h10, 32'h1);
    apb(1, 8'h20, 32'h1400);
    apb(1, 8'h04, 32'h96);
    wait_idle();
    apb(0, 8'h04, 0);
    chk(rd, 32'h96);
    apb(0, 8'h08, 0);
    chk(rd[3], 0);
    apb(1, 8'h10, 0);
    // slave frame: one word loaded, so the next frame boundary underruns
    apb(1, 8'h00, 32'h1);
    apb(1, 8'h04, 32'h81);
    ss0 <= 1'b0;
    si <= 1'b1;
    repeat (6) @(posedge clk);
    chk({so_oe, so}, 2'h3);
    // 800 ns link clock keeps well under the slave rate limit
    repeat (16)
    begin
      repeat (4) @(posedge clk);
      sck_i <= ~sck_i;
    end
    repeat (4) @(posedge clk);
    ss0 <= 1'b1;
    apb(0, 8'h08, 0);
    chk({rd[4], rd[2], err}, 3'h7);
    apb(0, 8'h04, 0);
    chk(rd, 32'hff);
    apb(1, 8'h00, 32'h41);
    apb(0, 8'h08, 0);
    chk({rd[4], rd[2], err}, 3'h0);
    apb(0, 8'h00, 0);
    chk(rd, 32'h1);
    final_report();
  end
endmodule
